// File: design/mpo_pkg.sv
// Purpose: Shared constants and carrier types of the motor PWM output stage.
// Assumes: 32-bit Wishbone words, 16-bit registers in the low half.
// Notes:   Offsets are byte addresses of aligned words.
`default_nettype none
package mpo_pkg;
  // Register byte offsets.
  localparam logic [7:0] A_TBC  = 8'h00; // time_base_control
  localparam logic [7:0] A_OC1  = 8'h04; // output_control_one
  localparam logic [7:0] A_OC2  = 8'h08; // output_control_two
  localparam logic [7:0] A_FAC  = 8'h0c; // fault_a_control
  localparam logic [7:0] A_FBC  = 8'h10; // fault_b_control
  localparam logic [7:0] A_OVR  = 8'h14; // output_override_control
  localparam logic [7:0] A_SEC  = 8'h18; // special_event_compare
  localparam logic [7:0] A_PER  = 8'h1c; // period_value buffer
  localparam logic [7:0] A_DTY0 = 8'h20; // first duty buffer, then one word each
  localparam logic [7:0] A_FST  = 8'h30; // fault status
  localparam logic [7:0] A_STEP = 8'h04;
  // Field positions.
  localparam int TBC_EN    = 15; // time_base_enable
  localparam int OC2_IUE   = 2;  // immediate_update
  localparam int OC2_OVERRIDE_SYNC = 1;  // override_sync
  localparam int OC2_UPDATE_DISABLE  = 0;  // update_disable
  localparam int FC_MODE   = 7;  // fault mode, 1 = cycle-by-cycle
  localparam int SEC_DIR   = 15; // trigger_direction
  // Values after reset.
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [14:0] RST_PER  = 15'h7fff;
  localparam logic [1:0]  RST_SYNC = 2'h3;
  // Time base mode field encodings.
  typedef enum logic [1:0] {
    TB_FREE   = 2'h0,
    TB_UPDOWN = 2'h1,
    TB_SINGLE = 2'h2,
    TB_DOUBLE = 2'h3
  } mpo_tb_mode_t;
  // Compare values handed to the comparators.
  typedef struct packed {
    logic [3:0][15:0] duty;
    logic [14:0]      period;
  } mpo_cmp_t;
endpackage
`default_nettype wire

// File: design/mpo_output_stage.sv
// Purpose: Output stage of a four-pair motor PWM unit.
// Assumes: Time base, comparators and dead-time units sit outside on i_sys_clk.
// Notes:   Fault pins are asynchronous and pass a two-flop synchroniser.
// Summary of operation
// - Independent pairs get no dead time; both pins may be active together.
// - Independent pair: one duty source feeds both pins; override picks PWM/off/on.
// - Mode 10 is single pulse: active on enable, inactive at duty match.
// - Single pulse period match ends pulse, clears enable, raises interrupt.
// - Override upper byte selects pins, lower byte gives their forced level.
// - Complementary forced low gives its own level, held off while high is active; no dead time.
// - Sync override applies at zero, and at period in center modes.
// - Reset strap 0 drives pins inactive, strap 1 leaves them tri-stated.
// - Two polarity bits map active and inactive levels, fault levels too.
// - A pin with its enable clear is released to general purpose use.
// - Four pair enables per fault input; all clear means no effect.
// - Eight fault state bits: clear drives inactive, set drives active.
// - Complementary pair with both fault states active: high side wins.
// - When both faults control a pin, fault A state wins.
// - Latched fault holds until pin high and flag cleared, then boundary.
// - Flag cleared while pin still low keeps the fault states.
// - Cycle-by-cycle fault holds while low, resumes at next boundary.
// - Each fault control register holds its own mode bit.
// - Update disable set and immediate clear blocks all buffer transfers.
// - Immediate update makes duty writes take effect at once, not period.
// - Trigger fires when counter equals special event compare value.
// - In up/down modes direction bit picks up or down phase.
// - Clear pair select bit means complementary; reset comes up complementary.
`default_nettype none
module mpo_output_stage (
  // Clock, reset and freeze.
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clk_en,
  // Wishbone slave.
  input  wire logic             i_wb_cyc,
  input  wire logic             i_wb_stb,
  input  wire logic             i_wb_we,
  input  wire logic [7:0]       i_wb_adr,
  input  wire logic [3:0]       i_wb_sel,
  input  wire logic [31:0]      i_wb_dat,
  output logic      [31:0]      o_wb_dat,
  output logic                  o_wb_ack,
  // Time base and comparator results.
  input  wire logic [14:0]      i_tb_count,
  input  wire logic             i_tb_down,
  input  wire logic             i_tb_zero,
  input  wire logic             i_tb_per_match,
  input  wire logic [3:0]       i_duty_pwm,
  input  wire logic [3:0]       i_dt_high,
  input  wire logic [3:0]       i_dt_low,
  // Configuration word and fault pins.
  input  wire logic             i_reset_pin_state_select,
  input  wire logic             i_high_side_polarity,
  input  wire logic             i_low_side_polarity,
  input  wire logic             i_fault_input_a_n,
  input  wire logic             i_fault_input_b_n,
  // Time base control and compare values.
  output logic                  o_tb_enable,
  output logic      [1:0]       o_tb_mode,
  output mpo_pkg::mpo_cmp_t     o_cmp,
  output logic                  o_single_pulse_irq,
  output logic                  o_sevt_trig,
  // Output pins.
  output logic      [3:0]       o_high_side_output,
  output logic      [3:0]       o_low_side_output,
  output logic      [3:0]       o_high_oe_n,
  output logic      [3:0]       o_low_oe_n
);

  // Byte-lane merge of a 16-bit register.
  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [31:0] dat,
                                        input logic [3:0]  sel);
    logic [15:0] m;
    m = {{8{sel[1]}}, {8{sel[0]}}};
    return (old_v & ~m) | (dat[15:0] & m);
  endfunction

  // Fault input kept or released at a boundary.
  function automatic logic hold_next(input logic cond, input logic bnd,
                                     input logic cur);
    return cond | (cur & ~bnd);
  endfunction

  logic        ack_q;
  logic [31:0] rdat_q;
  logic        tb_en_q;
  logic [1:0]  tb_mode_q;
  logic [11:0] oc1_q;
  logic [2:0]  oc2_q;
  logic [15:0] fac_q;
  logic [15:0] fbc_q;
  logic [15:0] ovr_q;
  logic [15:0] ovr_eff_q;
  logic [15:0] sec_q;
  logic [14:0] per_buf_q;
  logic [14:0] per_act_q;
  logic [3:0][15:0] dbuf_q;
  logic [3:0][15:0] dact_q;
  logic        cfg_done_q;
  logic        high_side_polarity_q;
  logic        low_side_polarity_q;
  logic [1:0]  fa_sync_q;
  logic [1:0]  fb_sync_q;
  logic        fa_flag_q;
  logic        fb_flag_q;
  logic        fa_hold_q;
  logic        fb_hold_q;
  logic        sp_irq_q;
  logic        sevt_q;
  logic [3:0]  hi_q;
  logic [3:0]  lo_q;
  logic [3:0]  hi_oe_n_q;
  logic [3:0]  lo_oe_n_q;

  // Bus decode; a request is served once and acked the next edge.
  wire         req     = i_wb_cyc & i_wb_stb & ~ack_q & i_clk_en;
  wire         wr      = req & i_wb_we;
  wire         wr_tbc  = wr & (i_wb_adr == mpo_pkg::A_TBC);
  wire         wr_oc1  = wr & (i_wb_adr == mpo_pkg::A_OC1);
  wire         wr_oc2  = wr & (i_wb_adr == mpo_pkg::A_OC2);
  wire         wr_fac  = wr & (i_wb_adr == mpo_pkg::A_FAC);
  wire         wr_fbc  = wr & (i_wb_adr == mpo_pkg::A_FBC);
  wire         wr_ovr  = wr & (i_wb_adr == mpo_pkg::A_OVR);
  wire         wr_sec  = wr & (i_wb_adr == mpo_pkg::A_SEC);
  wire         wr_per  = wr & (i_wb_adr == mpo_pkg::A_PER);
  wire         wr_fst  = wr & (i_wb_adr == mpo_pkg::A_FST) & i_wb_sel[0];
  wire [15:0]  tbc_rd  = {tb_en_q, 13'h0000, tb_mode_q};
  wire [15:0]  tbc_wv  = merge(tbc_rd, i_wb_dat, i_wb_sel);
  wire [15:0]  oc1_wv  = merge({4'h0, oc1_q}, i_wb_dat, i_wb_sel);
  wire [15:0]  oc2_wv  = merge({13'h0000, oc2_q}, i_wb_dat, i_wb_sel);
  wire [15:0]  per_wv  = merge({1'b0, per_buf_q}, i_wb_dat, i_wb_sel);

  // Mode and boundary decode.
  wire         center  = (tb_mode_q == mpo_pkg::TB_UPDOWN)
                       | (tb_mode_q == mpo_pkg::TB_DOUBLE);
  wire         single  = (tb_mode_q == mpo_pkg::TB_SINGLE);
  wire         bnd     = i_tb_zero | (center & i_tb_per_match);
  wire         upd_pt  = i_tb_zero | ((tb_mode_q == mpo_pkg::TB_DOUBLE) & i_tb_per_match);
  wire         update_disable    = oc2_q[mpo_pkg::OC2_UPDATE_DISABLE];
  wire         immediate_update     = oc2_q[mpo_pkg::OC2_IUE];
  wire         override_sync   = oc2_q[mpo_pkg::OC2_OVERRIDE_SYNC];
  wire         load    = ~update_disable & (upd_pt | ~tb_en_q);
  wire         sp_end  = single & tb_en_q & i_tb_per_match;
  wire [3:0]   indep   = oc1_q[11:8];
  wire [3:0]   pen_h   = oc1_q[7:4];
  wire [3:0]   pen_l   = oc1_q[3:0];

  // Trigger: counter match, phase checked only when counting up and down.
  wire         sevt_hit = tb_en_q & (i_tb_count == sec_q[14:0])
                        & (~center | (sec_q[mpo_pkg::SEC_DIR] == i_tb_down));

  // Fault conditions; latched mode also waits for the flag to clear.
  wire         fa_low  = ~fa_sync_q[1];
  wire         fb_low  = ~fb_sync_q[1];
  wire         fa_cond = fa_low | (~fac_q[mpo_pkg::FC_MODE] & fa_flag_q);
  wire         fb_cond = fb_low | (~fbc_q[mpo_pkg::FC_MODE] & fb_flag_q);
  wire         fa_clr  = wr_fst & i_wb_dat[0];
  wire         fb_clr  = wr_fst & i_wb_dat[1];
  wire [3:0]   fa_on   = fac_q[3:0] & {4{fa_hold_q}};
  wire [3:0]   fb_on   = fbc_q[3:0] & {4{fb_hold_q}};

  // Register read selection; unmapped words read zero.
  function automatic logic [15:0] rd_sel(input logic [7:0] a);
    case (a)
      mpo_pkg::A_TBC: rd_sel = tbc_rd;
      mpo_pkg::A_OC1: rd_sel = {4'h0, oc1_q};
      mpo_pkg::A_OC2: rd_sel = {13'h0000, oc2_q};
      mpo_pkg::A_FAC: rd_sel = fac_q;
      mpo_pkg::A_FBC: rd_sel = fbc_q;
      mpo_pkg::A_OVR: rd_sel = ovr_q;
      mpo_pkg::A_SEC: rd_sel = sec_q;
      mpo_pkg::A_PER: rd_sel = {1'b0, per_buf_q};
      8'h20:          rd_sel = dbuf_q[0];
      8'h24:          rd_sel = dbuf_q[1];
      8'h28:          rd_sel = dbuf_q[2];
      8'h2c:          rd_sel = dbuf_q[3];
      mpo_pkg::A_FST: rd_sel = {10'h000, fb_hold_q, fa_hold_q, fb_low, fa_low,
                                fb_flag_q, fa_flag_q};
      default:        rd_sel = mpo_pkg::RST_WORD;
    endcase
  endfunction

  // Per-pair duty buffers and pin equations.
  logic [3:0]  nh;
  logic [3:0]  nl;
  logic [3:0]  act_h;
  logic [3:0]  act_l;
  genvar p;
  generate
    for (p = 0; p < 4; p++)
    begin : g_pair
      wire wr_d = wr & (i_wb_adr == 8'(mpo_pkg::A_DTY0 + mpo_pkg::A_STEP * p));
      wire [15:0] d_wv = merge(dbuf_q[p], i_wb_dat, i_wb_sel);
      // Duty buffer and the copy the comparator uses.
      always_ff @(posedge i_sys_clk or negedge i_rst_n)
      begin
        if (!i_rst_n)
        begin
          dbuf_q[p] <= mpo_pkg::RST_WORD;
          dact_q[p] <= mpo_pkg::RST_WORD;
        end
        else if (i_clk_en)
        begin
          if (wr_d)
            dbuf_q[p] <= d_wv;
          if (wr_d && immediate_update)
            dact_q[p] <= d_wv;
          else if (load)
            dact_q[p] <= dbuf_q[p];
        end
      end
      // Single pulse: source idles once the enable has been cleared.
      wire sp_ok = ~single | tb_en_q;
      wire src_h = sp_ok & (indep[p] ? i_duty_pwm[p] : i_dt_high[p]);
      wire src_l = sp_ok & (indep[p] ? i_duty_pwm[p] : i_dt_low[p]);
      wire sel_h = ovr_eff_q[9 + 2 * p];
      wire sel_l = ovr_eff_q[8 + 2 * p];
      wire lvl_h = ovr_eff_q[1 + 2 * p];
      wire lvl_l = ovr_eff_q[2 * p];
      wire ov_h  = sel_h ? lvl_h : src_h;
      // A forced low side in a complementary pair is held inactive while the high side is active.
      wire ov_l  = sel_l ? (lvl_l & (indep[p] | ~ov_h)) : src_l;
      wire f_on  = fa_on[p] | fb_on[p];
      wire fh    = fa_on[p] ? fac_q[9 + 2 * p] : fbc_q[9 + 2 * p];
      wire fl    = fa_on[p] ? fac_q[8 + 2 * p] : fbc_q[8 + 2 * p];
      assign act_h[p] = f_on ? fh : ov_h;
      assign act_l[p] = f_on ? (fl & (indep[p] | ~fh)) : ov_l;
      assign nh[p]    = ~(act_h[p] ^ high_side_polarity_q);
      assign nl[p]    = ~(act_l[p] ^ low_side_polarity_q);
    end
  endgenerate

  // Bus answer; ack is a single-cycle pulse per request.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else if (i_clk_en)
    begin
      ack_q  <= req;
      rdat_q <= {16'h0000, rd_sel(i_wb_adr)}; // Called at the edge, so never stale.
    end
  end

  // Control registers; a time base control write beats single pulse end.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tb_en_q   <= 1'b0;
      tb_mode_q <= mpo_pkg::TB_FREE;
      oc2_q     <= 3'h0;
      fac_q     <= mpo_pkg::RST_WORD;
      fbc_q     <= mpo_pkg::RST_WORD;
      ovr_q     <= mpo_pkg::RST_WORD;
      sec_q     <= mpo_pkg::RST_WORD;
      per_buf_q <= mpo_pkg::RST_PER;
      per_act_q <= mpo_pkg::RST_PER;
      sp_irq_q  <= 1'b0;
      sevt_q    <= 1'b0;
    end
    else if (i_clk_en)
    begin
      if (wr_tbc)
        {tb_en_q, tb_mode_q} <= {tbc_wv[mpo_pkg::TBC_EN], tbc_wv[1:0]};
      else if (sp_end)
        tb_en_q <= 1'b0;
      if (wr_oc2)
        oc2_q <= oc2_wv[2:0];
      if (wr_fac)
        fac_q <= merge(fac_q, i_wb_dat, i_wb_sel) & 16'hff8f;
      if (wr_fbc)
        fbc_q <= merge(fbc_q, i_wb_dat, i_wb_sel) & 16'hff8f;
      if (wr_ovr)
        ovr_q <= merge(ovr_q, i_wb_dat, i_wb_sel);
      if (wr_sec)
        sec_q <= merge(sec_q, i_wb_dat, i_wb_sel);
      if (wr_per)
        per_buf_q <= per_wv[14:0];
      if (load)
        per_act_q <= per_buf_q;
      sp_irq_q <= sp_end;
      sevt_q   <= sevt_hit;
    end
  end

  // Pin control word; its reset value depends on the strap caught after release.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cfg_done_q <= 1'b0;
      oc1_q      <= 12'h000;
      high_side_polarity_q     <= 1'b1;
      low_side_polarity_q     <= 1'b1;
    end
    else if (i_clk_en)
    begin
      if (!cfg_done_q)
      begin
        cfg_done_q <= 1'b1;
        oc1_q      <= {4'h0, {8{~i_reset_pin_state_select}}};
        high_side_polarity_q     <= i_high_side_polarity;
        low_side_polarity_q     <= i_low_side_polarity;
      end
      else if (wr_oc1)
        oc1_q <= oc1_wv[11:0];
    end
  end

  // Effective override: immediate, or held for the next sync point.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      ovr_eff_q <= mpo_pkg::RST_WORD;
    else if (i_clk_en && (!override_sync || bnd))
      ovr_eff_q <= ovr_q;
  end

  // Fault synchronisers, sticky flags and hold state; a new event beats a clear.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      fa_sync_q <= mpo_pkg::RST_SYNC;
      fb_sync_q <= mpo_pkg::RST_SYNC;
      fa_flag_q <= 1'b0;
      fb_flag_q <= 1'b0;
      fa_hold_q <= 1'b0;
      fb_hold_q <= 1'b0;
    end
    else if (i_clk_en)
    begin
      fa_sync_q <= {fa_sync_q[0], i_fault_input_a_n};
      fb_sync_q <= {fb_sync_q[0], i_fault_input_b_n};
      fa_flag_q <= fa_low | (fa_flag_q & ~fa_clr);
      fb_flag_q <= fb_low | (fb_flag_q & ~fb_clr);
      fa_hold_q <= hold_next(fa_cond, bnd, fa_hold_q);
      fb_hold_q <= hold_next(fb_cond, bnd, fb_hold_q);
    end
  end

  // Pins stay released until the strap has been caught.
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hi_q      <= 4'h0;
      lo_q      <= 4'h0;
      hi_oe_n_q <= 4'hf;
      lo_oe_n_q <= 4'hf;
    end
    else if (i_clk_en)
    begin
      hi_q      <= nh;
      lo_q      <= nl;
      hi_oe_n_q <= ~(pen_h & {4{cfg_done_q}});
      lo_oe_n_q <= ~(pen_l & {4{cfg_done_q}});
    end
  end

  assign o_wb_ack           = ack_q;
  assign o_wb_dat           = rdat_q;
  assign o_tb_enable        = tb_en_q;
  assign o_tb_mode          = tb_mode_q;
  assign o_cmp              = '{duty: dact_q, period: per_act_q};
  assign o_single_pulse_irq = sp_irq_q;
  assign o_sevt_trig        = sevt_q;
  assign o_high_side_output = hi_q;
  assign o_low_side_output  = lo_q;
  assign o_high_oe_n        = hi_oe_n_q;
  assign o_low_oe_n         = lo_oe_n_q;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  sp_clear_a: assert property (i_clk_en && sp_end && !wr_tbc |=> !o_tb_enable)
    else $error("Single pulse end did not clear the enable.");
  sp_irq_a: assert property (i_clk_en && sp_end |=> o_single_pulse_irq)
    else $error("Single pulse end raised no interrupt.");
  fault_excl_a: assert property ((|(fa_on | fb_on)) |-> ((act_h & act_l & ~indep) == 4'h0))
    else $error("Complementary pair driven active on both sides.");
  upd_lock_a: assert property (update_disable && !immediate_update && !wr_tbc |=> $stable(o_cmp))
    else $error("Compare values moved under update lockout.");
  iue_now_a: assert property (i_clk_en && g_pair[0].wr_d && immediate_update
                              |=> o_cmp.duty[0] == $past(g_pair[0].d_wv))
    else $error("Immediate duty write did not take effect.");
  sevt_fire_a: assert property (i_clk_en && sevt_hit ##1 1 |-> o_sevt_trig)
    else $error("Special event trigger missed.");
  flt_keep_a: assert property (i_clk_en && fa_low |=> fa_hold_q)
    else $error("Fault A released while input low.");
  flt_none_a: assert property (fac_q[3:0] == 4'h0 |-> fa_on == 4'h0)
    else $error("Disabled fault A affected a pair.");
  override_sync_a: assert property (i_clk_en && override_sync && !bnd |=> $stable(ovr_eff_q))
    else $error("Synchronised override changed off a sync point.");
  pin_rel_a: assert property (i_clk_en && !pen_h[0] |=> o_high_oe_n[0])
    else $error("Disabled high pin still driven.");

endmodule
`default_nettype wire

// File: sim/mpo_fault_sense.sv
// Purpose: Fault sensing circuit model that drives the two fault pins.
// Assumes: Pins are open drain with a pull-up, so a released pin reads high.
// Notes:   Trip commands come from the bench just after a rising edge.
`default_nettype none
module mpo_fault_sense (
  // Clock and trip commands.
  input  wire logic i_sys_clk,
  input  wire logic i_trip_a,
  input  wire logic i_trip_b,
  // Fault pins, active low.
  output logic      o_fault_a_n,
  output logic      o_fault_b_n
);
  timeunit 1ns;
  timeprecision 100ps;
  // A tripped sensor pulls its pin low; on release the pull-up brings it high again.
  always_ff @(posedge i_sys_clk)
  begin
    o_fault_a_n <= ~i_trip_a;
    o_fault_b_n <= ~i_trip_b;
  end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// Purpose: Self-checking bench of the motor PWM output stage.
// Assumes: Time base and comparator results are driven here in place of their units.
// Notes:   Pin checks allow slack because the fault path adds synchroniser delay.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic              sys_clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [7:0]        adr = 8'h00;
  logic [31:0]       wdat = 32'h0, rdat;
  logic [14:0]       cnt = 15'h0;
  logic              down = 1'b0, zero = 1'b0, pmatch = 1'b0, strap = 1'b1, clk_en = 1'b1;
  logic [3:0]        duty = 4'h0, dth = 4'h0, dtl = 4'h0, hi, lo, hoe, loe;
  logic              trip_a = 1'b0, trip_b = 1'b0, fa_n, fb_n, tben, irq, trig;
  logic [1:0]        tbmode;
  mpo_pkg::mpo_cmp_t cmp;
  int                miscompares = 0, cmp_count = 0, cycles = 0;

  // Clock at 250 MHz.
  always #2 sys_clk = ~sys_clk;

  // Polarities are fixed: high side active high, low side active low.
  mpo_output_stage dut (.i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_clk_en(clk_en),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h3),
    .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_tb_count(cnt),
    .i_tb_down(down), .i_tb_zero(zero), .i_tb_per_match(pmatch), .i_duty_pwm(duty),
    .i_dt_high(dth), .i_dt_low(dtl), .i_reset_pin_state_select(strap),
    .i_high_side_polarity(1'b1), .i_low_side_polarity(1'b0), .i_fault_input_a_n(fa_n),
    .i_fault_input_b_n(fb_n), .o_tb_enable(tben), .o_tb_mode(tbmode), .o_cmp(cmp),
    .o_single_pulse_irq(irq), .o_sevt_trig(trig), .o_high_side_output(hi),
    .o_low_side_output(lo), .o_high_oe_n(hoe), .o_low_oe_n(loe));
  mpo_fault_sense fs (.i_sys_clk(sys_clk), .i_trip_a(trip_a), .i_trip_b(trip_b),
    .o_fault_a_n(fa_n), .o_fault_b_n(fb_n));

  // Shared helpers; every task returns just after a rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d,
                    output logic [31:0] q);
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {16'h0000, d};
    do
      @(posedge sys_clk);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    logic [31:0] q;
    wb(1'b0, a, 16'h0000, q);
    chk(nm, q, e);
  endtask
  task automatic pins(input logic [3:0] h, input logic [3:0] l);
    chk("pins", {24'h0, hi, lo}, {24'h0, h, l});
  endtask
  task automatic zp;
    zero <= 1'b1;
    tick(1);
    zero <= 1'b0;
    tick(1);
  endtask
  task automatic trig_try(input logic d, input logic e);
    cnt <= 15'h0005;
    down <= d;
    tick(1);
    cnt <= 15'h0000;
    tick(1);
    chk("trig", {31'h0, trig}, {31'h0, e});
  endtask
  // Reset for two cycles with the given strap, then check the pin enables.
  task automatic do_reset(input logic s);
    rst_n <= 1'b0;
    strap <= s;
    tick(2);
    chk("oe_rst", {24'h0, hoe, loe}, 32'h000000ff);
    rst_n <= 1'b1;
    tick(4);
    chk("oe", {24'h0, hoe, loe}, s ? 32'h000000ff : 32'h0);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // A hang counts as a mismatch; the full sequence needs well under a thousand cycles.
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      miscompares++;
      summarize();
    end
  end

  // Main sequence.
  initial
  begin
    do_reset(1'b1);
    rd(mpo_pkg::A_PER, 32'h00007fff, "per_rst");
    rd(8'h3c, 32'h0, "unmapped");
    do_reset(1'b0);
    pins(4'h0, 4'hf);
    rd(mpo_pkg::A_OC1, 32'h000000ff, "oc1");
    dth <= 4'h4;
    dtl <= 4'h8;
    wr(mpo_pkg::A_OC1, 16'h00fe);
    tick(2);
    chk("loe", {28'h0, loe}, 32'h1);
    pins(4'h4, 4'h7);
    dth <= 4'h0;
    dtl <= 4'h0;
    wr(mpo_pkg::A_OC1, 16'h00ff);
    wr(mpo_pkg::A_OVR, 16'h0303);
    tick(2);
    pins(4'h1, 4'hf);
    wr(mpo_pkg::A_OC1, 16'h03ff);
    duty <= 4'h2;
    tick(2);
    pins(4'h3, 4'hc);
    wr(mpo_pkg::A_OC2, 16'h0002);
    wr(mpo_pkg::A_OVR, 16'h0000);
    tick(3);
    pins(4'h3, 4'hc);
    zp();
    tick(2);
    pins(4'h2, 4'hd);
    wr(mpo_pkg::A_OC2, 16'h0000);
    wr(mpo_pkg::A_OC1, 16'h00ff);
    duty <= 4'h0;
    // Latched fault A against cycle-by-cycle fault B on the same pair.
    wr(mpo_pkg::A_FAC, 16'h0301);
    wr(mpo_pkg::A_FBC, 16'h0081);
    trip_a <= 1'b1;
    trip_b <= 1'b1;
    tick(8);
    pins(4'h1, 4'hf);
    wr(mpo_pkg::A_FST, 16'h0001);
    tick(3);
    pins(4'h1, 4'hf);
    trip_a <= 1'b0;
    trip_b <= 1'b0;
    tick(6);
    pins(4'h1, 4'hf);
    wr(mpo_pkg::A_FST, 16'h0003);
    tick(3);
    pins(4'h1, 4'hf);
    zp();
    tick(3);
    pins(4'h0, 4'hf);
    // Fault A has no pair enables here, fault B runs cycle by cycle.
    wr(mpo_pkg::A_FAC, 16'h0100);
    wr(mpo_pkg::A_FBC, 16'h0281);
    trip_a <= 1'b1;
    trip_b <= 1'b1;
    tick(8);
    pins(4'h1, 4'hf);
    trip_a <= 1'b0;
    trip_b <= 1'b0;
    tick(6);
    pins(4'h1, 4'hf);
    zp();
    tick(3);
    pins(4'h0, 4'hf);
    // Update lockout, then immediate duty update.
    wr(mpo_pkg::A_OC2, 16'h0001);
    wr(mpo_pkg::A_DTY0, 16'h1234);
    wr(mpo_pkg::A_PER, 16'h0100);
    zp();
    tick(2);
    chk("duty0", {16'h0, cmp.duty[0]}, 32'h0);
    chk("period", {17'h0, cmp.period}, 32'h7fff);
    wr(mpo_pkg::A_OC2, 16'h0005);
    wr(mpo_pkg::A_DTY0, 16'h00aa);
    tick(1);
    chk("duty0", {16'h0, cmp.duty[0]}, 32'h00aa);
    chk("period", {17'h0, cmp.period}, 32'h7fff);
    wr(mpo_pkg::A_OC2, 16'h0000);
    tick(2);
    chk("period", {17'h0, cmp.period}, 32'h0100);
    // Special event trigger, free running then up/down with the down phase.
    wr(mpo_pkg::A_SEC, 16'h0005);
    wr(mpo_pkg::A_TBC, 16'h8000);
    trig_try(1'b0, 1'b1);
    wr(mpo_pkg::A_SEC, 16'h8005);
    wr(mpo_pkg::A_TBC, 16'h8001);
    trig_try(1'b0, 1'b0);
    trig_try(1'b1, 1'b1);
    // Single pulse ends at the period match; a match under a frozen enable is ignored.
    dth <= 4'h1;
    wr(mpo_pkg::A_TBC, 16'h8002);
    tick(1);
    chk("tb_mode", {30'h0, tbmode}, 32'h2);
    chk("tb_en", {31'h0, tben}, 32'h1);
    pins(4'h1, 4'hf);
    clk_en <= 1'b0;
    pmatch <= 1'b1;
    tick(1);
    clk_en <= 1'b1;
    pmatch <= 1'b0;
    tick(1);
    chk("tb_en_frozen", {31'h0, tben}, 32'h1);
    pmatch <= 1'b1;
    tick(1);
    pmatch <= 1'b0;
    tick(1);
    chk("irq", {31'h0, irq}, 32'h1);
    chk("tb_en", {31'h0, tben}, 32'h0);
    tick(1);
    pins(4'h0, 4'hf);
    summarize();
  end
endmodule
`default_nettype wire
